// file: src/cit_consts.vh
// Constants for the instruction cycle timing decoder.
// Notes on behaviour
// RULE1: Instruction duration is counted in plain clock cycles, never machine cycles.
// RULE2: Most instructions take as many clock cycles as they have bytes.
// RULE3: A conditional branch not taken finishes one cycle sooner than when taken.
// RULE4: Add, add-carry, subtract-borrow and logic with working register: one byte, one cycle.
// RULE5: Arithmetic or logic with indirect RAM operand: one byte, two cycles.
// RULE6: Arithmetic or logic with direct or immediate operand: two bytes, two cycles.
// RULE7: Immediate into direct byte logic: three bytes, three cycles; accumulator into direct: two.
// RULE8: Increment or decrement of accumulator or register one cycle; direct or indirect two.
// RULE9: Incrementing the data pointer is one byte and one cycle.
// RULE10: Accumulator-only operations are one byte and one cycle.
// RULE11: Code byte reads relative to data pointer or program counter: one byte, three cycles.
// RULE12: External data moves, either direction or address width: one byte, three cycles.
// RULE13: Loading the data pointer with a 16-bit constant: three bytes, three cycles.
// RULE14: Push and pop of a direct byte: two bytes, two cycles each.
// RULE15: Direct to direct copy or immediate to direct store: three bytes, three cycles.
// RULE16: Any move writing indirect internal RAM takes two cycles.
// RULE17: Exchange with register one cycle; with direct, indirect or low nibble two cycles.
// RULE18: Carry clear, set, complement one byte one cycle; direct bit two bytes two cycles.
// RULE19: Logic immediate into accumulator two bytes two cycles; with register one and one.
// RULE20: The one unassigned opcode behaves exactly like the no-operation instruction.
// RULE21: Length and cycles come from a lookup table; next issue waits for the count.
`ifndef CIT_CONSTS_VH
`define CIT_CONSTS_VH
`define CIT_OP_W     8
`define CIT_LEN_W    2
`define CIT_CYC_W    4
`define CIT_ENT_W    7
`define CIT_F_COND   6
`define CIT_F_LEN    5:4
`define CIT_F_CYC    3:0
`define CIT_L1       2'h1
`define CIT_L2       2'h2
`define CIT_L3       2'h3
`define CIT_C0       4'h0
`define CIT_C1       4'h1
`define CIT_C2       4'h2
`define CIT_C3       4'h3
`define CIT_C4       4'h4
`define CIT_C5       4'h5
`define CIT_C6       4'h6
`define CIT_C8       4'h8
`define CIT_PLAIN    1'b0
`define CIT_COND     1'b1
`define CIT_TAKEN_EXTRA 4'h1
`define CIT_ST_IDLE  2'h1
`define CIT_ST_EXEC  2'h2
`endif

// file: src/cit_cycle_timer.v
// Down counter that holds one instruction for its number of clock cycles.
`timescale 1ns/1ps
module cit_cycle_timer #(
   parameter CNT_W = 4
) (
   input  wire             clock,
   input  wire             rst_n,
   input  wire             load,
   input  wire [CNT_W-1:0] load_val,
   output reg  [CNT_W-1:0] count_q,
   output wire             busy,
   output wire             last
);
   localparam [CNT_W-1:0] ZERO = {CNT_W{1'b0}};
   localparam [CNT_W-1:0] ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

   reg [CNT_W-1:0] count_d;

   assign busy = (count_q != ZERO);
   assign last = (count_q == ONE);

   // A load in the final cycle replaces the count, so issues can run back to back.
   always @* begin
      count_d = count_q;
      if (load) begin
         count_d = load_val; // [RULE21]
      end else if (busy) begin
         count_d = count_q - ONE; // [RULE1]
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= ZERO;
      end else begin
         count_q <= count_d;
      end
   end
endmodule

// file: src/cit_decoder.v
// Opcode length and cycle decoder with an issue sequencer for the core pipeline.
`timescale 1ns/1ps
`include "cit_consts.vh"
module cit_decoder #(
   parameter CNT_W = 16
) (
   input  wire                   clock,
   input  wire                   nrst,
   input  wire                   op_valid,
   input  wire [`CIT_OP_W-1:0]   op_code,
   input  wire                   op_taken,
   output wire                   op_ready,
   output reg                    op_issue_q,
   output reg  [`CIT_OP_W-1:0]   op_code_q,
   output reg  [`CIT_LEN_W-1:0]  op_len_q,
   output reg  [`CIT_CYC_W-1:0]  op_cycles_q,
   output reg                    op_cond_q,
   output reg                    op_taken_q,
   output wire                   op_busy,
   output wire                   op_last,
   output reg  [CNT_W-1:0]       retired_q,
   output reg  [CNT_W-1:0]       clocks_q
);
   localparam [1:0]       ST_IDLE = `CIT_ST_IDLE;
   localparam [1:0]       ST_EXEC = `CIT_ST_EXEC;
   localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // Packs one table entry: branch flag, byte length and not-taken cycle count.
   function [`CIT_ENT_W-1:0] mk;
      input       cond;
      input [1:0] len;
      input [3:0] cyc;
      begin
         mk = {cond, len, cyc};
      end
   endfunction

   // Timing table. Conditional entries hold the not-taken count.
   function [`CIT_ENT_W-1:0] tbl;
      input [7:0] op;
      reg   [3:0] hi;
      reg   [3:0] lo;
      begin
         hi  = op[7:4];
         lo  = op[3:0];
         tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
         if (lo[3]) begin
            case (hi)
               4'h0, 4'h1:         tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE8]
               4'h2, 4'h3, 4'h9:   tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE4]
               4'h4, 4'h5, 4'h6:   tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE19]
               4'h7, 4'h8, 4'hA:   tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE2]
               4'hB:               tbl = mk(`CIT_COND,  `CIT_L3, `CIT_C3);
               4'hC:               tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE17]
               4'hD:               tbl = mk(`CIT_COND,  `CIT_L2, `CIT_C2);
               4'hE, 4'hF:         tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE2]
               default:            tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
            endcase
         end else if (lo[3:1] == 3'h3) begin
            case (hi)
               4'h0, 4'h1:         tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C2); // [RULE8]
               4'h2, 4'h3, 4'h9:   tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C2); // [RULE5]
               4'h4, 4'h5, 4'h6:   tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C2); // [RULE5]
               4'h7, 4'hA:         tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE16]
               4'h8:               tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2);
               4'hB:               tbl = mk(`CIT_COND,  `CIT_L3, `CIT_C4);
               4'hC, 4'hD:         tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C2); // [RULE17]
               4'hE:               tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C2);
               4'hF:               tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C2); // [RULE16]
               default:            tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C2);
            endcase
         end else begin
            case (lo)
               4'h0: begin
                  case (hi)
                     4'h0:             tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
                     4'h1, 4'h2, 4'h3: tbl = mk(`CIT_COND,  `CIT_L3, `CIT_C3);
                     4'h4, 4'h5:       tbl = mk(`CIT_COND,  `CIT_L2, `CIT_C2);
                     4'h6, 4'h7:       tbl = mk(`CIT_COND,  `CIT_L2, `CIT_C2);
                     4'h8:             tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C4);
                     4'h9:             tbl = mk(`CIT_PLAIN, `CIT_L3, `CIT_C3); // [RULE13]
                     4'hA, 4'hB:       tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2);
                     4'hC, 4'hD:       tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE14]
                     4'hE, 4'hF:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C3); // [RULE12]
                     default:          tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
                  endcase
               end
               4'h1: begin
                  tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C4);
               end
               4'h2: begin
                  case (hi)
                     4'h0, 4'h1:       tbl = mk(`CIT_PLAIN, `CIT_L3, `CIT_C5);
                     4'h2, 4'h3:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C6);
                     4'h4, 4'h5, 4'h6: tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE7]
                     4'h7, 4'h8:       tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2);
                     4'h9, 4'hA:       tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2);
                     4'hB, 4'hC, 4'hD: tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE18]
                     4'hE, 4'hF:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C3); // [RULE12]
                     default:          tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
                  endcase
               end
               4'h3: begin
                  case (hi)
                     4'h0, 4'h1:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE10]
                     4'h2, 4'h3:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE10]
                     4'h4, 4'h5, 4'h6: tbl = mk(`CIT_PLAIN, `CIT_L3, `CIT_C3); // [RULE7]
                     4'h7:             tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C4);
                     4'h8, 4'h9:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C3); // [RULE11]
                     4'hA:             tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE9]
                     4'hB, 4'hC, 4'hD: tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE18]
                     4'hE, 4'hF:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C3); // [RULE12]
                     default:          tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
                  endcase
               end
               4'h4: begin
                  case (hi)
                     4'h0, 4'h1:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE8]
                     4'h2, 4'h3, 4'h9: tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE6]
                     4'h4, 4'h5, 4'h6: tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE19]
                     4'h7:             tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2);
                     4'h8:             tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C8);
                     4'hA:             tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C4);
                     4'hB:             tbl = mk(`CIT_COND,  `CIT_L3, `CIT_C3);
                     4'hC, 4'hD:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE10]
                     4'hE, 4'hF:       tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE10]
                     default:          tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
                  endcase
               end
               4'h5: begin
                  case (hi)
                     4'h0, 4'h1:       tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE8]
                     4'h2, 4'h3, 4'h9: tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE6]
                     4'h4, 4'h5, 4'h6: tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE6]
                     4'h7, 4'h8:       tbl = mk(`CIT_PLAIN, `CIT_L3, `CIT_C3); // [RULE15]
                     4'hA:             tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1); // [RULE20]
                     4'hB:             tbl = mk(`CIT_COND,  `CIT_L3, `CIT_C4);
                     4'hC:             tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE17]
                     4'hD:             tbl = mk(`CIT_COND,  `CIT_L3, `CIT_C3);
                     4'hE, 4'hF:       tbl = mk(`CIT_PLAIN, `CIT_L2, `CIT_C2); // [RULE2]
                     default:          tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
                  endcase
               end
               default: begin
                  tbl = mk(`CIT_PLAIN, `CIT_L1, `CIT_C1);
               end
            endcase
         end
      end
   endfunction

   reg                   rst_meta_q;
   reg                   rst_sync_q;
   reg  [1:0]            state_q;
   reg  [1:0]            state_d;
   wire [`CIT_ENT_W-1:0] entry;
   wire                  accept;
   wire                  timer_busy;
   wire                  timer_last;
   wire [`CIT_CYC_W-1:0] timer_count;
   reg  [`CIT_CYC_W-1:0] run_cycles;

   // Reset is asserted at once but released two clocks late to avoid metastable release.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign entry = tbl(op_code); // [RULE21]

   // A new opcode is taken when idle or in the last cycle of the current one, so the
   // issue rate equals the table count and no bubble is inserted.
   assign op_ready = rst_sync_q & ((state_q == ST_IDLE) | timer_last); // [RULE21]
   assign accept   = op_valid & op_ready;
   assign op_busy  = timer_busy;
   assign op_last  = timer_last;

   // The branch outcome must be known at issue; a taken branch costs one more cycle.
   always @* begin
      run_cycles = entry[`CIT_F_CYC];
      if (entry[`CIT_F_COND] && op_taken) begin
         run_cycles = entry[`CIT_F_CYC] + `CIT_TAKEN_EXTRA; // [RULE3]
      end
   end

   cit_cycle_timer #(
      .CNT_W (`CIT_CYC_W)
   ) u_timer (
      .clock    (clock),
      .rst_n    (rst_sync_q),
      .load     (accept),
      .load_val (run_cycles),
      .count_q  (timer_count),
      .busy     (timer_busy),
      .last     (timer_last)
   );

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (accept) begin
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (timer_last && !accept) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         state_q     <= ST_IDLE;
         op_issue_q  <= 1'b0;
         op_code_q   <= {`CIT_OP_W{1'b0}};
         op_len_q    <= {`CIT_LEN_W{1'b0}};
         op_cycles_q <= `CIT_C0;
         op_cond_q   <= 1'b0;
         op_taken_q  <= 1'b0;
         retired_q   <= {CNT_W{1'b0}};
         clocks_q    <= {CNT_W{1'b0}};
      end else begin
         state_q    <= state_d;
         op_issue_q <= accept;
         if (accept) begin
            op_code_q   <= op_code;
            op_len_q    <= entry[`CIT_F_LEN];
            op_cycles_q <= run_cycles; // [RULE1]
            op_cond_q   <= entry[`CIT_F_COND];
            op_taken_q  <= entry[`CIT_F_COND] & op_taken; // [RULE3]
         end
         if (timer_last) begin
            retired_q <= retired_q + CNT_ONE;
         end
         // Counts only clocks spent executing, so software can compare it with the table.
         if (timer_busy) begin
            clocks_q <= clocks_q + CNT_ONE; // [RULE1]
         end
      end
   end
endmodule

// file: verif/cit_decoder_monitor.sv
// Concurrent checks on the ports of the instruction timing decoder.
`timescale 1ns/1ps
module cit_decoder_monitor #(
   parameter CNT_W = 16
) (
   input wire             clock,
   input wire             nrst,
   input wire             op_valid,
   input wire [7:0]       op_code,
   input wire             op_taken,
   input wire             op_ready,
   input wire             op_issue_q,
   input wire [7:0]       op_code_q,
   input wire [1:0]       op_len_q,
   input wire [3:0]       op_cycles_q,
   input wire             op_cond_q,
   input wire             op_taken_q,
   input wire             op_busy,
   input wire             op_last,
   input wire [CNT_W-1:0] retired_q,
   input wire [CNT_W-1:0] clocks_q
);
   reg  [3:0] run_q;
   wire [3:0] run_d = op_issue_q ? 4'h1 : run_q + 4'h1;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) run_q <= 4'h0;
      else run_q <= run_d;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   accept_issue_a: assert property (op_valid && op_ready |=> op_issue_q)
      else $error("no issue pulse after an accept");
   issue_cause_a: assert property (op_issue_q |-> $past(op_valid && op_ready) &&
      op_code_q == $past(op_code)) else $error("issue without matching accept");
   hold_off_a: assert property (op_busy && !op_last |-> !op_ready)
      else $error("ready raised before the last cycle");
   span_count_a: assert property (op_last |-> run_d == op_cycles_q)
      else $error("busy span differs from cycle count");
   taken_flag_a: assert property (op_issue_q |->
      op_taken_q == (op_cond_q && $past(op_taken))) else $error("taken flag wrong");
   branch_cost_a: assert property (op_issue_q && op_code_q == 8'h40 |->
      op_cycles_q == (op_taken_q ? 4'h3 : 4'h2)) else $error("branch cycle count wrong");
   nop_alias_a: assert property (op_issue_q && op_code_q == 8'hA5 |->
      {op_cond_q, op_len_q, op_cycles_q} == 7'h11) else $error("spare opcode not a no-op");
   pointer_inc_a: assert property (op_issue_q && op_code_q == 8'hA3 |->
      {op_len_q, op_cycles_q} == 6'h11) else $error("pointer increment timing wrong");
   pointer_load_a: assert property (op_issue_q && op_code_q == 8'h90 |->
      {op_len_q, op_cycles_q} == 6'h33) else $error("pointer load timing wrong");
   ext_move_a: assert property (op_issue_q && op_code_q[7:5] == 3'h7 &&
      op_code_q[3:2] == 2'h0 && op_code_q[1:0] != 2'h1 |->
      {op_len_q, op_cycles_q} == 6'h13) else $error("external move wrong");
   retire_step_a: assert property (op_last |=> retired_q == $past(retired_q) + 1'b1)
      else $error("retired count did not step");
   clock_step_a: assert property (op_busy |=> clocks_q == $past(clocks_q) + 1'b1)
      else $error("busy clock count did not step");
   cover property (op_issue_q && op_taken_q);
   cover property (op_last && op_valid && op_ready);
   cover property (op_issue_q && op_cycles_q == 4'h3);
endmodule

bind cit_decoder cit_decoder_monitor #(.CNT_W(CNT_W)) u_monitor (
   .clock(clock), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .op_taken(op_taken),
   .op_ready(op_ready), .op_issue_q(op_issue_q), .op_code_q(op_code_q), .op_len_q(op_len_q),
   .op_cycles_q(op_cycles_q), .op_cond_q(op_cond_q), .op_taken_q(op_taken_q),
   .op_busy(op_busy), .op_last(op_last), .retired_q(retired_q), .clocks_q(clocks_q)
);

// file: verif/cpu_instruction_cycle_timing_tb.sv
// Self-checking bench for the instruction timing decoder.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   total_checks = total_checks + 1; \
   if ((g) !== (e)) begin \
      fail_count = fail_count + 1; \
      $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); \
   end \
end
module cpu_instruction_cycle_timing_tb;
   reg         clock;
   reg         nrst;
   reg         op_valid;
   reg  [7:0]  op_code;
   reg         op_taken;
   wire        op_ready, op_issue_q, op_cond_q, op_taken_q, op_busy, op_last;
   wire [7:0]  op_code_q;
   wire [1:0]  op_len_q;
   wire [3:0]  op_cycles_q;
   wire [15:0] retired_q, clocks_q;
   integer     fail_count, total_checks, n_issued, n_cycles, run_len, i;
   reg  [15:0] seed;
   reg  [6:0]  pend;
   reg  [7:0]  pcode;
   reg         ptk;
   reg  [3:0]  ec;
   cit_decoder #(.CNT_W(16)) uut (
      .clock(clock), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .op_taken(op_taken),
      .op_ready(op_ready), .op_issue_q(op_issue_q), .op_code_q(op_code_q), .op_len_q(op_len_q),
      .op_cycles_q(op_cycles_q), .op_cond_q(op_cond_q), .op_taken_q(op_taken_q),
      .op_busy(op_busy), .op_last(op_last), .retired_q(retired_q), .clocks_q(clocks_q));
   // Packs {conditional, bytes, not-taken cycles} for every one of the 256 opcodes.
   function [6:0] exp_op(input [7:0] op);
      reg [3:0] h;
      reg [3:0] l;
      begin
         h = op[7:4];
         l = op[3:0];
         exp_op = 7'h22;
         if (l >= 4'h8) begin
            exp_op = 7'h11;
            if (h == 4'h7 || h == 4'h8 || h == 4'hA) exp_op = 7'h22;
            if (h == 4'hB) exp_op = 7'h73;
            if (h == 4'hD) exp_op = 7'h62;
         end else if (l >= 4'h6) begin
            exp_op = 7'h12;
            if (h == 4'h7 || h == 4'h8 || h == 4'hA) exp_op = 7'h22;
            if (h == 4'hB) exp_op = 7'h74;
         end else if (l == 4'h5) begin
            if (h == 4'h7 || h == 4'h8) exp_op = 7'h33;
            if (h == 4'hA) exp_op = 7'h11;
            if (h == 4'hB) exp_op = 7'h74;
            if (h == 4'hD) exp_op = 7'h73;
         end else if (l == 4'h4) begin
            if (h <= 4'h1 || h >= 4'hC) exp_op = 7'h11;
            if (h == 4'h8) exp_op = 7'h18;
            if (h == 4'hA) exp_op = 7'h14;
            if (h == 4'hB) exp_op = 7'h73;
         end else if (l == 4'h1) exp_op = 7'h24;
         else case (op)
            8'h00, 8'h03, 8'h13, 8'h23, 8'h33: exp_op = 7'h11;
            8'hA3, 8'hB3, 8'hC3, 8'hD3: exp_op = 7'h11;
            8'h43, 8'h53, 8'h63, 8'h90: exp_op = 7'h33;
            8'h83, 8'h93, 8'hE0, 8'hE2: exp_op = 7'h13;
            8'hE3, 8'hF0, 8'hF2, 8'hF3: exp_op = 7'h13;
            8'h10, 8'h20, 8'h30: exp_op = 7'h73;
            8'h40, 8'h50, 8'h60, 8'h70: exp_op = 7'h62;
            8'h02, 8'h12: exp_op = 7'h35;
            8'h22, 8'h32: exp_op = 7'h16;
            8'h73: exp_op = 7'h14;
            8'h80: exp_op = 7'h24;
            default: ;
         endcase
      end
   endfunction
   function [15:0] lfsr_next(input [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task close_out;
      begin
         $display("checks %0d mismatches %0d", total_checks, fail_count);
         if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // The offer stays up until accepted, so back-to-back calls exercise the refusal window.
   task offer(input [7:0] op, input tk);
      integer w;
      begin
         op_valid <= 1'b1;
         op_code <= op;
         op_taken <= tk;
         w = 0;
         @(posedge clock);
         while (op_ready !== 1'b1 && w < 20) begin
            w = w + 1;
            @(posedge clock);
         end
         if (w >= 20) `CHK("accept", 1'b1, 1'b0)
      end
   endtask
   task idle(input integer n);
      begin
         op_valid <= 1'b0;
         repeat (n) @(posedge clock);
      end
   endtask
   always @(posedge clock) begin
      if (op_valid === 1'b1 && op_ready === 1'b1) begin
         pend <= exp_op(op_code);
         ptk <= op_taken;
         pcode <= op_code;
      end
   end
   always @(negedge clock) begin
      if (op_issue_q === 1'b1) begin
         run_len = 1;
         ec = pend[3:0] + (pend[6] & ptk);
         n_issued = n_issued + 1;
         n_cycles = n_cycles + ec;
         `CHK("code", pcode, op_code_q)
         `CHK("length", pend[5:4], op_len_q)
         `CHK("cycles", ec, op_cycles_q)
         `CHK("taken", pend[6] & ptk, op_taken_q)
         `CHK("cond", pend[6], op_cond_q)
      end else if (op_busy === 1'b1) run_len = run_len + 1;
      if (op_last === 1'b1) `CHK("span", ec, run_len[3:0])
   end
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Both phases finish in well under two thousand cycles; the limit leaves wide margin.
   initial begin
      #100000;
      `CHK("watchdog", 1'b0, 1'b1)
      close_out;
   end
   initial begin
      nrst = 1'b0;
      op_valid = 1'b0;
      op_code = 8'h00;
      op_taken = 1'b0;
      {fail_count, total_checks, n_issued, n_cycles, run_len} = 0;
      seed = 16'h3A0A;
      repeat (8) @(posedge clock);
      `CHK("ready in reset", 1'b0, op_ready)
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      $display("test reset done");
      for (i = 0; i < 256; i = i + 1)
         offer(i[7:0], i[4]);
      offer(8'h40, 1'b1);
      offer(8'h60, 1'b1);
      idle(4);
      $display("test sweep done");
      for (i = 0; i < 400; i = i + 1) begin
         seed = lfsr_next(seed);
         if (seed[15:13] == 3'h0) idle(1 + seed[1:0]);
         else offer(seed[7:0], seed[8]);
      end
      // The longest instruction runs eight cycles, so this drains any last issue.
      idle(10);
      $display("test random done");
      `CHK("retired", n_issued[15:0], retired_q)
      `CHK("clocks", n_cycles[15:0], clocks_q)
      close_out;
   end
endmodule
